/* rtl/acw_pkg.sv */
package acw_pkg;

   // ----------------------------------------
   // register addresses on the special-function bus
   // ----------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'hE8;
   localparam logic [7:0] ADDR_CONFIG = 8'hBC;
   localparam logic [7:0] ADDR_RES_HIGH = 8'hBE;
   localparam logic [7:0] ADDR_RES_LOW = 8'hBD;
   localparam logic [7:0] ADDR_UPPER_HIGH = 8'hC4;
   localparam logic [7:0] ADDR_UPPER_LOW = 8'hC3;
   localparam logic [7:0] ADDR_LOWER_HIGH = 8'hC6;
   localparam logic [7:0] ADDR_LOWER_LOW = 8'hC5;

   // ----------------------------------------
   // control register field positions
   // ----------------------------------------
   localparam int CTL_ENABLE = 7;
   localparam int CTL_TRACK_MODE = 6;
   localparam int CTL_COMPLETE = 5;
   localparam int CTL_BUSY = 4;
   localparam int CTL_WINDOW = 3;
   localparam int CTL_SRC_MSB = 2;
   localparam int CTL_SRC_LSB = 0;

   // ----------------------------------------
   // configuration register field positions
   // ----------------------------------------
   localparam int CFG_DIV_MSB = 7;
   localparam int CFG_DIV_LSB = 3;
   localparam int CFG_JUSTIFY = 2;

   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [4:0] RST_DIVIDER = 5'h1F;
   localparam logic RST_JUSTIFY = 1'b0;
   localparam logic [7:0] RST_RESULT = 8'h00;
   localparam logic [7:0] RST_UPPER = 8'hFF;
   localparam logic [7:0] RST_LOWER = 8'h00;

   // ----------------------------------------
   // start-of-conversion source codes
   // ----------------------------------------
   localparam logic [2:0] SRC_SOFTWARE = 3'h0;
   localparam logic [2:0] SRC_TIMER0 = 3'h1;
   localparam logic [2:0] SRC_TIMER2 = 3'h2;
   localparam logic [2:0] SRC_TIMER1 = 3'h3;
   localparam logic [2:0] SRC_EXT_PIN = 3'h4;
   localparam logic [2:0] SRC_TIMER3 = 3'h5;
   localparam logic [2:0] SRC_TIMER4 = 3'h6;
   localparam logic [2:0] SRC_TIMER5 = 3'h7;

   // ----------------------------------------
   // sequence lengths in SAR clock periods
   // ----------------------------------------
   localparam int TRACK_SAR_CLKS = 3;
   localparam int CONV_SAR_CLKS = 11;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_TRACK = 3'b010,
      ST_CONVERT = 3'b100
   } acw_state_t;

   // places a 10-bit word into the high:low byte pair
   function automatic logic [15:0] justify(input logic [9:0] word, input logic leftJust);
      justify = leftJust ? {word, 6'h00} : {6'h00, word};
   endfunction

endpackage

/* rtl/acw_sar_div.sv */
`timescale 1ns/1ps
module acw_sar_div (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // control
   input wire logic restart,
   input wire logic [4:0] divider,
   // enable pulse at the SAR rate
   output logic sarTick
);

   logic [4:0] count_r;

   // restart aligns the first SAR period with the start event
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         count_r <= 5'h00;
      end else if (restart || count_r >= divider) begin
         count_r <= 5'h00;
      end else begin
         count_r <= count_r + 5'h01;
      end
   end

   assign sarTick = !restart && (count_r >= divider);

endmodule // acw_sar_div

/* rtl/acw_window_cmp.sv */
`timescale 1ns/1ps
module acw_window_cmp (
   // compared word and limits, all in register format
   input wire logic [15:0] word,
   input wire logic [15:0] upperLimit,
   input wire logic [15:0] lowerLimit,
   // result
   output logic match
);

   logic insideMode;
   logic insideHit;
   logic outsideHit;

   // the mode follows only from how the two limits relate
   assign insideMode = lowerLimit > upperLimit;
   assign insideHit = (word > upperLimit) && (word < lowerLimit);
   assign outsideHit = (word > upperLimit) || (word < lowerLimit);
   assign match = insideMode ? insideHit : outsideHit;

endmodule // acw_window_cmp

/* rtl/acw_converter_ctrl.sv */
`timescale 1ns/1ps
module acw_converter_ctrl #(
   parameter int CONV_CLKS = acw_pkg::CONV_SAR_CLKS
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // special-function register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic [7:0] sfrWrData,
   output logic [7:0] sfrRdData_r,
   // start sources
   input wire logic [5:0] timerOvf,
   input wire logic extStartPin,
   // analog core
   input wire logic [9:0] convResult,
   output logic analogEnable_r,
   output logic trackEnable_r,
   output logic convRunning_r,
   output logic convDone_r
);

   // ----------------------------------------
   // register state
   // ----------------------------------------
   logic enable_r;
   logic trackMode_r;
   logic complete_r;
   logic window_r;
   logic [2:0] srcSel_r;
   logic [4:0] divider_r;
   logic justify_r;
   logic [7:0] resHigh_r;
   logic [7:0] resLow_r;
   logic [7:0] upperHigh_r;
   logic [7:0] upperLow_r;
   logic [7:0] lowerHigh_r;
   logic [7:0] lowerLow_r;

   logic complete_nxt;
   logic window_nxt;

   // ----------------------------------------
   // sequencer state
   // ----------------------------------------
   acw_pkg::acw_state_t state_r;
   acw_pkg::acw_state_t state_nxt;
   logic [3:0] sarCnt_r;
   logic [3:0] sarCnt_nxt;

   // ----------------------------------------
   // external pin synchroniser
   // ----------------------------------------
   logic extSync1_r;
   logic extSync2_r;
   logic extPrev_r;
   logic extRise;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         extSync1_r <= 1'b0;
         extSync2_r <= 1'b0;
         extPrev_r <= 1'b0;
      end else begin
         extSync1_r <= extStartPin;
         extSync2_r <= extSync1_r;
         extPrev_r <= extSync2_r;
      end
   end

   assign extRise = extSync2_r && !extPrev_r;

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   logic wrControl;
   logic wrConfig;
   logic wrResHigh;
   logic wrResLow;
   logic wrUpperHigh;
   logic wrUpperLow;
   logic wrLowerHigh;
   logic wrLowerLow;

   assign wrControl = sfrWr && (sfrAddr == acw_pkg::ADDR_CONTROL);
   assign wrConfig = sfrWr && (sfrAddr == acw_pkg::ADDR_CONFIG);
   assign wrResHigh = sfrWr && (sfrAddr == acw_pkg::ADDR_RES_HIGH);
   assign wrResLow = sfrWr && (sfrAddr == acw_pkg::ADDR_RES_LOW);
   assign wrUpperHigh = sfrWr && (sfrAddr == acw_pkg::ADDR_UPPER_HIGH);
   assign wrUpperLow = sfrWr && (sfrAddr == acw_pkg::ADDR_UPPER_LOW);
   assign wrLowerHigh = sfrWr && (sfrAddr == acw_pkg::ADDR_LOWER_HIGH);
   assign wrLowerLow = sfrWr && (sfrAddr == acw_pkg::ADDR_LOWER_LOW);

   // ----------------------------------------
   // start-of-conversion selection
   // ----------------------------------------
   logic swStart;
   logic startEvt;
   logic extSelected;
   logic useDelay;
   logic isIdle;

   assign isIdle = (state_r == acw_pkg::ST_IDLE);
   assign swStart = wrControl && sfrWrData[acw_pkg::CTL_BUSY];
   assign extSelected = (srcSel_r == acw_pkg::SRC_EXT_PIN);

   always_comb begin
      case (srcSel_r)
         acw_pkg::SRC_SOFTWARE: startEvt = swStart;
         acw_pkg::SRC_TIMER0: startEvt = timerOvf[0];
         acw_pkg::SRC_TIMER2: startEvt = timerOvf[2];
         acw_pkg::SRC_TIMER1: startEvt = timerOvf[1];
         acw_pkg::SRC_EXT_PIN: startEvt = extRise;
         acw_pkg::SRC_TIMER3: startEvt = timerOvf[3];
         acw_pkg::SRC_TIMER4: startEvt = timerOvf[4];
         acw_pkg::SRC_TIMER5: startEvt = timerOvf[5];
         default: startEvt = 1'b0;
      endcase
   end

   // pin source skips the extra tracking even in delayed mode
   assign useDelay = trackMode_r && !extSelected;

   // ----------------------------------------
   // SAR clock divider
   // ----------------------------------------
   logic sarTick;
   logic startNow;

   assign startNow = isIdle && enable_r && startEvt;

   acw_sar_div u_div (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .restart(startNow),
      .divider(divider_r),
      .sarTick(sarTick)
   );

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   logic convEnd;
   logic trackDone;
   logic convLast;

   assign trackDone = sarTick && (sarCnt_r == 4'(acw_pkg::TRACK_SAR_CLKS - 1));
   assign convLast = sarTick && (sarCnt_r == 4'(CONV_CLKS - 1));
   assign convEnd = enable_r && (state_r == acw_pkg::ST_CONVERT) && convLast;

   always_comb begin
      state_nxt = state_r;
      sarCnt_nxt = sarCnt_r;
      case (state_r)
         acw_pkg::ST_IDLE: begin
            sarCnt_nxt = 4'h0;
            if (startNow) begin
               state_nxt = useDelay ? acw_pkg::ST_TRACK : acw_pkg::ST_CONVERT;
            end
         end
         acw_pkg::ST_TRACK: begin
            if (trackDone) begin
               state_nxt = acw_pkg::ST_CONVERT;
               sarCnt_nxt = 4'h0;
            end else if (sarTick) begin
               sarCnt_nxt = sarCnt_r + 4'h1;
            end
         end
         acw_pkg::ST_CONVERT: begin
            if (convLast) begin
               state_nxt = acw_pkg::ST_IDLE;
               sarCnt_nxt = 4'h0;
            end else if (sarTick) begin
               sarCnt_nxt = sarCnt_r + 4'h1;
            end
         end
         default: begin
            state_nxt = acw_pkg::ST_IDLE;
            sarCnt_nxt = 4'h0;
         end
      endcase
      // shutdown abandons any conversion in flight
      if (!enable_r) begin
         state_nxt = acw_pkg::ST_IDLE;
         sarCnt_nxt = 4'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= acw_pkg::ST_IDLE;
         sarCnt_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         sarCnt_r <= sarCnt_nxt;
      end
   end

   // ----------------------------------------
   // result placement and window detector
   // ----------------------------------------
   logic [15:0] newWord;
   logic winMatch;

   assign newWord = acw_pkg::justify(convResult, justify_r);

   // limits are kept in register format, so they follow the justify choice
   acw_window_cmp u_win (
      .word(newWord),
      .upperLimit({upperHigh_r, upperLow_r}),
      .lowerLimit({lowerHigh_r, lowerLow_r}),
      .match(winMatch)
   );

   // ----------------------------------------
   // sticky flags: the set wins over a clear
   // ----------------------------------------
   logic clrComplete;
   logic clrWindow;

   assign clrComplete = wrControl && !sfrWrData[acw_pkg::CTL_COMPLETE];
   assign clrWindow = wrControl && !sfrWrData[acw_pkg::CTL_WINDOW];
   assign complete_nxt = convEnd || (complete_r && !clrComplete);
   assign window_nxt = (convEnd && winMatch) || (window_r && !clrWindow);

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         enable_r <= acw_pkg::RST_CONTROL[acw_pkg::CTL_ENABLE];
         trackMode_r <= acw_pkg::RST_CONTROL[acw_pkg::CTL_TRACK_MODE];
         srcSel_r <= acw_pkg::RST_CONTROL[acw_pkg::CTL_SRC_MSB:acw_pkg::CTL_SRC_LSB];
         complete_r <= acw_pkg::RST_CONTROL[acw_pkg::CTL_COMPLETE];
         window_r <= acw_pkg::RST_CONTROL[acw_pkg::CTL_WINDOW];
      end else begin
         if (wrControl) begin
            enable_r <= sfrWrData[acw_pkg::CTL_ENABLE];
            trackMode_r <= sfrWrData[acw_pkg::CTL_TRACK_MODE];
            srcSel_r <= sfrWrData[acw_pkg::CTL_SRC_MSB:acw_pkg::CTL_SRC_LSB];
         end
         complete_r <= complete_nxt;
         window_r <= window_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         divider_r <= acw_pkg::RST_DIVIDER;
         justify_r <= acw_pkg::RST_JUSTIFY;
         upperHigh_r <= acw_pkg::RST_UPPER;
         upperLow_r <= acw_pkg::RST_UPPER;
         lowerHigh_r <= acw_pkg::RST_LOWER;
         lowerLow_r <= acw_pkg::RST_LOWER;
      end else begin
         if (wrConfig) begin
            divider_r <= sfrWrData[acw_pkg::CFG_DIV_MSB:acw_pkg::CFG_DIV_LSB];
            justify_r <= sfrWrData[acw_pkg::CFG_JUSTIFY];
         end
         if (wrUpperHigh) upperHigh_r <= sfrWrData;
         if (wrUpperLow) upperLow_r <= sfrWrData;
         if (wrLowerHigh) lowerHigh_r <= sfrWrData;
         if (wrLowerLow) lowerLow_r <= sfrWrData;
      end
   end

   // a completing conversion overrides a software write in the same cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         resHigh_r <= acw_pkg::RST_RESULT;
         resLow_r <= acw_pkg::RST_RESULT;
      end else if (convEnd) begin
         resHigh_r <= newWord[15:8];
         resLow_r <= newWord[7:0];
      end else begin
         if (wrResHigh) resHigh_r <= sfrWrData;
         if (wrResLow) resLow_r <= sfrWrData;
      end
   end

   // ----------------------------------------
   // read path, one cycle of latency
   // ----------------------------------------
   logic busy;
   logic [7:0] controlRead;
   logic [7:0] configRead;
   logic [7:0] rdMux;

   assign busy = !isIdle;
   assign controlRead = {enable_r, trackMode_r, complete_r, busy, window_r, srcSel_r};
   assign configRead = {divider_r, justify_r, 2'b00};

   always_comb begin
      case (sfrAddr)
         acw_pkg::ADDR_CONTROL: rdMux = controlRead;
         acw_pkg::ADDR_CONFIG: rdMux = configRead;
         acw_pkg::ADDR_RES_HIGH: rdMux = resHigh_r;
         acw_pkg::ADDR_RES_LOW: rdMux = resLow_r;
         acw_pkg::ADDR_UPPER_HIGH: rdMux = upperHigh_r;
         acw_pkg::ADDR_UPPER_LOW: rdMux = upperLow_r;
         acw_pkg::ADDR_LOWER_HIGH: rdMux = lowerHigh_r;
         acw_pkg::ADDR_LOWER_LOW: rdMux = lowerLow_r;
         default: rdMux = 8'h00;
      endcase
   end

   // ----------------------------------------
   // outputs to the analog core
   // ----------------------------------------
   logic trackNow;

   // in delayed pin mode the hold is released only while the pin is low
   assign trackNow = enable_r && (state_nxt != acw_pkg::ST_CONVERT)
                     && !(trackMode_r && extSelected && extSync2_r);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sfrRdData_r <= 8'h00;
         analogEnable_r <= 1'b0;
         trackEnable_r <= 1'b0;
         convRunning_r <= 1'b0;
         convDone_r <= 1'b0;
      end else begin
         sfrRdData_r <= rdMux;
         analogEnable_r <= enable_r;
         trackEnable_r <= trackNow;
         convRunning_r <= (state_nxt == acw_pkg::ST_CONVERT);
         convDone_r <= convEnd;
      end
   end

endmodule // acw_converter_ctrl

/* tb/acw_monitor.sv */
`timescale 1ns/1ps
module acw_monitor #(
   parameter int CONV_CLKS = 11
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic [7:0] sfrWrData,
   input wire logic [7:0] sfrRdData_r,
   // start sources and analog core
   input wire logic [5:0] timerOvf,
   input wire logic extStartPin,
   input wire logic [9:0] convResult,
   input wire logic analogEnable_r,
   input wire logic trackEnable_r,
   input wire logic convRunning_r,
   input wire logic convDone_r
);
   // ----------------------------------------
   // shadows of written fields
   // ----------------------------------------
   logic [7:0] ctlShadow_r;
   logic [4:0] divShadow_r;
   logic [15:0] runCnt_r;
   logic ctlWr;
   logic idleNormal;
   logic swStart;
   logic timerHit;
   logic [2:0] src;

   assign src = ctlShadow_r[2:0];
   assign ctlWr = sfrWr && sfrAddr == acw_pkg::ADDR_CONTROL;
   assign idleNormal = analogEnable_r && ctlShadow_r[7] && !ctlShadow_r[6] && trackEnable_r && !convRunning_r
      && !convDone_r;
   assign swStart = ctlWr && sfrWrData[4] && sfrWrData[7] && ctlShadow_r[7] && src == acw_pkg::SRC_SOFTWARE;
   assign timerHit = (src == acw_pkg::SRC_TIMER0) ? timerOvf[0] : (src == acw_pkg::SRC_TIMER2) ? timerOvf[2]
      : (src == acw_pkg::SRC_TIMER1) ? timerOvf[1] : (src == acw_pkg::SRC_TIMER3) ? timerOvf[3]
      : (src == acw_pkg::SRC_TIMER4) ? timerOvf[4] : (src == acw_pkg::SRC_TIMER5) ? timerOvf[5] : 1'b0;

   // the whole written byte is shadowed, flags and busy included; only the mode fields matter here
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctlShadow_r <= 8'h00;
         divShadow_r <= 5'h1F;
         runCnt_r <= 16'h0000;
      end else begin
         ctlShadow_r <= ctlWr ? sfrWrData : ctlShadow_r;
         divShadow_r <= (sfrWr && sfrAddr == acw_pkg::ADDR_CONFIG) ? sfrWrData[7:3] : divShadow_r;
         runCnt_r <= convRunning_r ? runCnt_r + 16'h0001 : 16'h0000;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   enable_on_a: assert property (ctlWr && sfrWrData[7] |-> ##[1:2] analogEnable_r)
      else $error("enable write did not power the converter");
   enable_off_a: assert property (ctlWr && !sfrWrData[7] |-> ##[1:2] !analogEnable_r)
      else $error("disable write did not shut the converter down");
   shutdown_idle_a: assert property (!analogEnable_r && !$past(analogEnable_r) |-> !convRunning_r)
      else $error("conversion running while shut down");
   no_track_conv_a: assert property (convRunning_r |-> !trackEnable_r)
      else $error("tracking while converting");
   done_pulse_a: assert property (convDone_r |-> $past(convRunning_r) && !convRunning_r ##1 !convDone_r)
      else $error("completion pulse not tied to end of conversion");
   conv_length_a: assert property ($fell(convRunning_r) && convDone_r
      |-> 32'(runCnt_r) == CONV_CLKS * (32'(divShadow_r) + 1))
      else $error("conversion phase length wrong for divider");
   sw_start_a: assert property (idleNormal && swStart |-> ##[1:2] convRunning_r)
      else $error("software start did not convert at once");
   delay_track_a: assert property (ctlShadow_r[6] && swStart && !convRunning_r && !convDone_r
      |=> (!convRunning_r) [*3] ##[1:200] convRunning_r)
      else $error("delayed mode skipped extra tracking");
   timer_start_a: assert property (idleNormal && timerHit && !ctlWr |-> ##[1:2] convRunning_r)
      else $error("selected timer overflow did not start");
   pin_start_a: assert property (analogEnable_r && src == acw_pkg::SRC_EXT_PIN && !convRunning_r && !convDone_r
      && $rose(extStartPin) |-> ##[3:5] convRunning_r)
      else $error("pin edge start late or missing");
   done_sticky_a: assert property (sfrAddr == acw_pkg::ADDR_CONTROL && !sfrWr
      ##1 sfrAddr == acw_pkg::ADDR_CONTROL && sfrRdData_r[5] |=> sfrRdData_r[5])
      else $error("completion flag dropped without a write");
   window_sticky_a: assert property (sfrAddr == acw_pkg::ADDR_CONTROL && !sfrWr
      ##1 sfrAddr == acw_pkg::ADDR_CONTROL && sfrRdData_r[3] |=> sfrRdData_r[3])
      else $error("window flag dropped without a write");
endmodule // acw_monitor

/* tb/acw_partner.sv */
`timescale 1ns/1ps
module acw_partner (
   // clock
   input wire logic clk_sys,
   // conversion phase from the controller
   input wire logic convRunning_r,
   // start sources and analog core
   output logic [5:0] timerOvf,
   output logic extStartPin,
   output logic [9:0] convResult
);
   logic [9:0] resultVal = 10'h000;

   // sample only valid while converting, so a late capture sees garbage
   assign convResult = convRunning_r ? resultVal : ~resultVal;

   initial begin
      timerOvf = 6'h00;
      extStartPin = 1'b0;
   end

   task automatic pulse(input logic [5:0] m);
      @(posedge clk_sys);
      #1;
      timerOvf = m;
      @(posedge clk_sys);
      #1;
      timerOvf = 6'h00;
   endtask

   task automatic set_pin(input logic v);
      @(posedge clk_sys);
      #1;
      extStartPin = v;
   endtask

   task automatic set_result(input logic [9:0] v);
      resultVal = v;
   endtask
endmodule // acw_partner

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam int CONV = 2;
   localparam int DIV = 1;
   localparam int KN = CONV * (DIV + 1);
   logic clk_sys, arst_n, sfrWr, extStartPin, seen;
   logic analogEnable_r, trackEnable_r, convRunning_r, convDone_r;
   logic [7:0] sfrAddr, sfrWrData, sfrRdData_r, rdVal;
   logic [5:0] timerOvf;
   logic [9:0] convResult;
   logic [7:0] rAddr [9] = '{8'hE8, 8'hBC, 8'hBE, 8'hBD, 8'hC4, 8'hC3, 8'hC6, 8'hC5, 8'h00};
   logic [7:0] rVal [9] = '{8'h00, 8'hF8, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
   // clear, expected flag, result
   logic [11:0] winTab [8] = '{12'hC41, 12'h440, 12'h840, 12'hC7F, 12'h880, 12'hC3F, 12'hC81, 12'h860};
   // source code, timer mask
   logic [8:0] tmrTab [7] = '{9'h000, 9'h041, 9'h084, 9'h0C2, 9'h148, 9'h190, 9'h1E0};
   int err_count = 0;
   int n_tests = 0;
   int n;

   acw_converter_ctrl #(.CONV_CLKS(CONV)) DUT (.clk_sys(clk_sys), .arst_n(arst_n), .sfrAddr(sfrAddr),
      .sfrWr(sfrWr), .sfrWrData(sfrWrData), .sfrRdData_r(sfrRdData_r), .timerOvf(timerOvf),
      .extStartPin(extStartPin), .convResult(convResult), .analogEnable_r(analogEnable_r),
      .trackEnable_r(trackEnable_r), .convRunning_r(convRunning_r), .convDone_r(convDone_r));
   acw_partner PARTNER (.clk_sys(clk_sys), .convRunning_r(convRunning_r), .timerOvf(timerOvf),
      .extStartPin(extStartPin), .convResult(convResult));

   // ----------------------------------------
   // bus and check helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      sfrAddr = a;
      sfrWrData = d;
      sfrWr = 1'b1;
      @(posedge clk_sys);
      #1;
      sfrWr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      #1;
      sfrAddr = a;
      @(posedge clk_sys);
      #1;
      rdVal = sfrRdData_r;
   endtask

   // bounded wait; n is cycles since the caller's last edge
   task automatic wait_done();
      n = 0;
      while (convDone_r !== 1'b1 && n < 400) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (convDone_r !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED completion wait expected done seen timeout");
         stop_test();
      end
   endtask

   task automatic quiet(input int cycles);
      seen = 1'b0;
      repeat (cycles) begin
         @(posedge clk_sys);
         #1;
         seen = seen | convRunning_r;
      end
   endtask

   task automatic sw_conv(input logic [9:0] v);
      PARTNER.set_result(v);
      // flag bits written as one, so earlier flags survive the start
      wr(8'hE8, 8'hB8);
      wait_done();
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 9; i++) begin
         rd(rAddr[i]);
         chk("reset value", 16'(rdVal), 16'(rVal[i]));
      end
   endtask

   task automatic t_normal();
      wr(8'hBC, 8'h08);
      wr(8'hE8, 8'h80);
      quiet(2);
      chk("tracking when idle", 16'(trackEnable_r), 16'h0001);
      sw_conv(10'h2A5);
      chk("normal length", 16'(n), 16'(KN));
      rd(8'hBE);
      chk("right high byte", 16'(rdVal), 16'h0002);
      rd(8'hBD);
      chk("right low byte", 16'(rdVal), 16'h00A5);
      rd(8'hE8);
      chk("control after done", 16'(rdVal & 8'hF7), 16'h00A0);
      wr(8'hBC, 8'h0C);
      sw_conv(10'h2A5);
      rd(8'hBE);
      chk("left high byte", 16'(rdVal), 16'h00A9);
      rd(8'hBD);
      chk("left low byte", 16'(rdVal), 16'h0040);
      wr(8'hBC, 8'h08);
      wr(8'hE8, 8'h80);
      rd(8'hE8);
      chk("flags cleared", 16'(rdVal), 16'h0080);
   endtask

   task automatic set_limits(input logic [15:0] gt, input logic [15:0] lt);
      wr(8'hC4, gt[15:8]);
      wr(8'hC3, gt[7:0]);
      wr(8'hC6, lt[15:8]);
      wr(8'hC5, lt[7:0]);
   endtask

   task automatic t_window();
      set_limits(16'h0040, 16'h0080);
      for (int i = 0; i < 8; i++) begin
         if (i == 5) begin
            set_limits(16'h0080, 16'h0040);
         end
         if (winTab[i][11]) begin
            wr(8'hE8, 8'h80);
         end
         sw_conv(winTab[i][9:0]);
         rd(8'hE8);
         chk("window flag", 16'(rdVal[3]), 16'(winTab[i][10]));
      end
   endtask

   task automatic t_timers();
      for (int i = 0; i < 7; i++) begin
         wr(8'hE8, {5'b10000, tmrTab[i][8:6]});
         // every other overflow must be ignored
         PARTNER.pulse(6'h3F & ~tmrTab[i][5:0]);
         quiet(4);
         chk("stray start", 16'(seen), 16'h0000);
         if (i == 0) begin
            wr(8'hE8, 8'h90);
         end else begin
            PARTNER.pulse(tmrTab[i][5:0]);
         end
         wait_done();
         chk("selected start length", 16'(n), 16'(KN));
      end
   endtask

   task automatic t_delayed();
      wr(8'hE8, 8'hC0);
      wr(8'hE8, 8'hD0);
      wait_done();
      chk("delayed length", 16'(n), 16'((3 + CONV) * (DIV + 1)));
      wr(8'hE8, 8'hC4);
      quiet(3);
      chk("tracking while pin low", 16'(trackEnable_r), 16'h0001);
      PARTNER.set_pin(1'b1);
      wait_done();
      chk("pin start without delay", 16'(n >= KN && n <= KN + 4), 16'h0001);
      quiet(2);
      chk("hold while pin high", 16'(trackEnable_r), 16'h0000);
      PARTNER.set_pin(1'b0);
   endtask

   task automatic t_abort();
      wr(8'hBC, 8'h38);
      wr(8'hE8, 8'h80);
      wr(8'hE8, 8'h90);
      rd(8'hE8);
      chk("busy while converting", 16'(rdVal[4]), 16'h0001);
      wr(8'hE8, 8'h00);
      quiet(20);
      chk("aborted run", 16'({seen, analogEnable_r}), 16'h0000);
      rd(8'hE8);
      chk("no flag on abort", 16'(rdVal), 16'h0000);
      wr(8'hE8, 8'h10);
      quiet(6);
      chk("start while disabled", 16'(seen), 16'h0000);
   endtask

   // ----------------------------------------
   // clock, reset and sequence
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      arst_n = 1'b0;
      sfrAddr = 8'h00;
      sfrWr = 1'b0;
      sfrWrData = 8'h00;
      repeat (20) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      t_reset();
      t_normal();
      t_window();
      t_timers();
      t_delayed();
      t_abort();
      stop_test();
   end
endmodule // testbench

bind acw_converter_ctrl acw_monitor #(.CONV_CLKS(CONV_CLKS)) MON (.clk_sys(clk_sys), .arst_n(arst_n),
   .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrWrData(sfrWrData), .sfrRdData_r(sfrRdData_r), .timerOvf(timerOvf),
   .extStartPin(extStartPin), .convResult(convResult), .analogEnable_r(analogEnable_r),
   .trackEnable_r(trackEnable_r), .convRunning_r(convRunning_r), .convDone_r(convDone_r));
